// *** bench/cpp_ctrl_checker.sv ***
// Purpose : Port level assertions for cpp_ctrl.
// Assumes : Outputs are registered one cycle after their inputs.
// Notes   : Bound to every cpp_ctrl instance.
`default_nettype none

module cpp_ctrl_checker (
  input wire logic       clk_i,
  input wire logic       rstn_i,
  input wire logic       rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic       vbus_present_i,
  input wire logic       input_overvoltage_i,
  input wire logic       boost_usb500_select_i,
  input wire logic       bat_above_low_i,
  input wire logic       vbus_below_sleep_i,
  input wire logic [2:0] current_limit_pin_i,
  input wire logic       sys_above_2v2_i,
  input wire logic       light_load_i,
  input wire logic       input_current_overload_i,
  input wire logic       input_voltage_overload_i,
  input wire logic       power_good_n_o,
  input wire logic       int_n_o,
  input wire logic       test_load_en_o,
  input wire logic       switch_en_o,
  input wire logic       boost_en_o,
  input wire logic [2:0] in_cur_limit_o,
  input wire logic       charge_cut_o,
  input wire logic       pfm_en_o
);
  import cpp_pkg::*;
  // ----
  // Rules
  // ----
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  wire logic boost_ok = boost_usb500_select_i && bat_above_low_i && vbus_below_sleep_i;
  sequence int_low_s; !int_n_o [*8]; endsequence
  sequence run_s; switch_en_o && $past(switch_en_o) && $past(sys_above_2v2_i); endsequence

  AST_TEST_LOAD: assert property ($rose(test_load_en_o) |->
    $past(vbus_present_i && !input_overvoltage_i)) else $error("test load without source");
  AST_PG_INT: assert property ($fell(power_good_n_o) |-> ##[0:2] !int_n_o)
    else $error("no interrupt on power good");
  AST_INT_PULSE: assert property ($fell(int_n_o) |-> int_low_s)
    else $error("interrupt pulse too short");
  AST_CONV_START: assert property ($rose(switch_en_o) |-> !power_good_n_o)
    else $error("converter started without good source");
  AST_SOFT_START: assert property (!$past(sys_above_2v2_i) |-> in_cur_limit_o == ICL_100MA)
    else $error("limit not clamped at low system rail");
  AST_LOWER_LIM: assert property (run_s |-> in_cur_limit_o <= $past(current_limit_pin_i))
    else $error("limit above pin setting");
  AST_BOOST_GATE: assert property ($rose(boost_en_o) |-> $past(boost_ok) && $past(boost_ok, 8))
    else $error("boost started without conditions or delay");
  AST_PFM: assert property ($rose(pfm_en_o) |-> $past(light_load_i))
    else $error("pulse mode without light load");
  AST_DPM: assert property (charge_cut_o |->
    $past(input_current_overload_i || input_voltage_overload_i)) else $error("cut without overload");
  AST_RD_IDLE: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data outside read slot");
endmodule

bind cpp_ctrl cpp_ctrl_checker u_chk (.*);

`default_nettype wire

// *** bench/cpp_phy_model.sv ***
// Purpose : USB PHY model driving the source type and select pins.
// Assumes : kind_i 0 host 100 mA, 1 host 500 mA, 2 charger.
// Notes   : Pins are levels that follow kind_i one cycle later.
`default_nettype none

module cpp_phy_model (
  input  wire logic       clk_i,
  input  wire logic [1:0] kind_i,
  output var  logic       source_type_o,
  output var  logic       select_o
);
  timeunit 1ns;
  timeprecision 1ns;
  always_ff @(posedge clk_i) begin
    source_type_o <= (kind_i != 2'h2);
    select_o      <= (kind_i == 2'h1);
  end
endmodule

`default_nettype wire

// *** bench/tb.sv ***
// Purpose : Self-checking bench of cpp_ctrl with a host and a USB PHY model.
// Assumes : Short timer parameters 8, 16 and 12 cycles.
// Notes   : Reads are scored from a queue of expected values.
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i, rstn_i = 1'h0, ce_i = 1'h1, wr_i = 1'h0, rd_i = 1'h0, rd_d = 1'h0;
  logic [3:0] addr_i = 4'h0, vin_limit_o;
  logic [7:0] wdata_i = 8'h00, v, rdata_o, exp_q[$];
  logic host_mode_i = 1'h0, vbus_present_i = 1'h0, input_overvoltage_i = 1'h0;
  logic vbus_load_ok_i = 1'h1, charge_en_n_i = 1'h0, bat_good_i = 1'h1, bat_depleted_i = 1'h0;
  logic bat_above_low_i = 1'h0, vbus_below_sleep_i = 1'h0, bat_below_minsys_i = 1'h0;
  logic sys_above_2v2_i = 1'h1, sys_below_bat_i = 1'h0, minsys_regulating_i = 1'h0;
  logic input_current_overload_i = 1'h0, input_voltage_overload_i = 1'h0;
  logic boost_fault_i = 1'h0, light_load_i = 1'h0, source_type_i, boost_usb500_select_i;
  logic [2:0] current_limit_pin_i = 3'h7, in_cur_limit_o, min_sys_code_o;
  logic power_good_n_o, int_n_o, test_load_en_o, switch_en_o, battery_switch_on_o;
  logic boost_en_o, boost_cur_high_o, charge_cut_o, pfm_en_o;
  logic [1:0] kind = 2'h0;
  int seed = 48, error_cnt = 0, comparisons = 0;

  cpp_ctrl #(.QUAL_CYC_P(26'd8), .RETRY_CYC_P(26'd16), .BOOST_CYC_P(26'd12)) u_cpp_ctrl (.*);
  cpp_phy_model u_cpp_phy_model (.clk_i(clk_i), .kind_i(kind), .source_type_o(source_type_i),
    .select_o(boost_usb500_select_i));

  // ----
  // Tasks
  // ----
  task automatic check(input string n, input logic [7:0] s, input logic [7:0] e);
    comparisons++;
    if (s !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a; wdata_i <= d; wr_i <= 1'h1;
    @(posedge clk_i);
    wr_i <= 1'h0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk_i);
    addr_i <= a; rd_i <= 1'h1; exp_q.push_back(e);
    @(posedge clk_i);
    rd_i <= 1'h0;
    @(posedge clk_i);
  endtask
  task automatic end_of_test();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    clk_i = 1'h0;
    forever #25 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    rd_d <= rd_i;
    if (rd_d) check("rdata", rdata_o, exp_q.pop_front());
  end
  initial begin
    #100000;
    error_cnt++;
    end_of_test();
  end

  // ----
  // Scenarios
  // ----
  initial begin
    repeat (20) @(posedge clk_i);
    rstn_i <= 1'h1;
    rd(4'h0, 8'h32); rd(4'h1, 8'h1b); rd(4'h7, 8'h00);
    wr(4'hf, 8'hff); rd(4'hf, 8'h00); wr(4'h8, 8'hff); rd(4'h8, 8'h00);
    vbus_present_i <= 1'h1;
    repeat (40) @(posedge clk_i);
    rd(4'h0, 8'hb0);
    vbus_present_i <= 1'h0;
    repeat (10) @(posedge clk_i);
    rd(4'h0, 8'h30);
    bat_good_i <= 1'h0; vbus_present_i <= 1'h1;
    repeat (40) @(posedge clk_i);
    check("pg_n", power_good_n_o, 1'h0);
    check("int_n", int_n_o, 1'h0);
    check("sw_en", switch_en_o, 1'h1);
    check("bat_sw", battery_switch_on_o, 1'h1);
    rd(4'h8, 8'h44);
    wr(4'h0, 8'h3a); repeat (3) @(posedge clk_i);
    check("icl", in_cur_limit_o, 3'h2);
    check("vin", vin_limit_o, 4'h7);
    current_limit_pin_i <= 3'h1; repeat (3) @(posedge clk_i);
    check("icl", in_cur_limit_o, 3'h1);
    sys_above_2v2_i <= 1'h0; repeat (3) @(posedge clk_i);
    check("icl", in_cur_limit_o, 3'h0);
    sys_above_2v2_i <= 1'h1; current_limit_pin_i <= 3'h7; kind <= 2'h2;
    wr(4'h7, 8'h80); repeat (10) @(posedge clk_i);
    rd(4'h7, 8'h00); rd(4'h0, 8'h3f);
    input_voltage_overload_i <= 1'h1; repeat (3) @(posedge clk_i);
    check("cut", charge_cut_o, 1'h1);
    rd(4'h8, 8'h8c);
    input_voltage_overload_i <= 1'h0;
    wr(4'h7, 8'h20); @(posedge clk_i);
    check("bat_sw", battery_switch_on_o, 1'h0);
    host_mode_i <= 1'h1; wr(4'h7, 8'h00); wr(4'h0, 8'hbf); vbus_present_i <= 1'h0;
    repeat (5) @(posedge clk_i);
    vbus_present_i <= 1'h1; repeat (20) @(posedge clk_i);
    rd(4'h0, 8'hbf); check("sw_en", switch_en_o, 1'h0);
    wr(4'h0, 8'h3f); repeat (3) @(posedge clk_i);
    check("sw_en", switch_en_o, 1'h1); host_mode_i <= 1'h0;
    repeat (4) begin
      v = 8'($random(seed));
      {light_load_i, bat_below_minsys_i, minsys_regulating_i, sys_below_bat_i} <= v[7:4];
      wr(4'h1, v); rd(4'h1, v & 8'h3f);
      check("minsys", min_sys_code_o, v[3:1]);
      check("boost_cur", boost_cur_high_o, v[0]);
    end
    {light_load_i, bat_below_minsys_i, minsys_regulating_i, sys_below_bat_i} <= 4'h0;
    vbus_present_i <= 1'h0; repeat (10) @(posedge clk_i);
    rd(4'h8, 8'h00);
    kind <= 2'h1; bat_above_low_i <= 1'h1; vbus_below_sleep_i <= 1'h1;
    wr(4'h1, 8'h2b); repeat (30) @(posedge clk_i);
    check("boost", boost_en_o, 1'h1);
    rd(4'h8, 8'hc0);
    boost_fault_i <= 1'h1; @(posedge clk_i);
    boost_fault_i <= 1'h0;
    rd(4'h9, 8'h40); rd(4'h9, 8'h00);
    end_of_test();
  end
endmodule

`default_nettype wire

// *** src/cpp_ctrl.sv ***
// Purpose : Input qualification, current limit detection, high-impedance,
//           converter start, boost gating and status of a one-cell charger.
// Assumes : All analog comparator results arrive synchronous to clk_i.
// Notes   : Register port answers every read on the next cycle.
//
// Function
// - Source is good only below overvoltage and above 3.8 V under 30 mA load.
// - On good source set power-good status, pull power-good pin low, interrupt.
// - Failed poor-source check repeats every 2 seconds until it passes.
// - Detection runs on every plug-in unless held high-impedance in host mode.
// - Pin map: 100 mA or 500 mA with status 01, else 3 A with 10.
// - 100 mA host port with good battery enters high-impedance, sets its bit.
// - In host mode high-impedance holds until the host writes its bit to 0.
// - Default mode clears high-impedance on removal; reruns detection on new source.
// - Host sets force-detection bit; device clears it when detection completes.
// - After limit set enable converter; battery switch off if charging disabled.
// - System below 2.2 V forces 100 mA; else lower of register and pin.
// - Boost needs battery ok, low input, select pin high, config 10, 220 ms.
// - Boost reports source status 11 and selects output current by a bit.
// - Boost fault sets the fault bit and interrupts.
// - Minimum system field drives regulation; status bit shows that regulation.
// - Input current or voltage overload cuts charge current; status bit shows it.
// - System below battery turns battery switch on; depletion turns it off.
// - Light load uses pulse-frequency control when battery low or charge disabled.
// - Reset returns every register to default and the port is ready.
//
// The placing of the registers and the plain strobed port were left to the implementer.
`default_nettype none

module cpp_ctrl #(
  parameter logic [cpp_pkg::TMR_W-1:0] QUAL_CYC_P  = cpp_pkg::QUAL_CYC,
  parameter logic [cpp_pkg::TMR_W-1:0] RETRY_CYC_P = cpp_pkg::RETRY_CYC,
  parameter logic [cpp_pkg::TMR_W-1:0] BOOST_CYC_P = cpp_pkg::BOOST_DLY_CYC
) (
  input  wire logic                      clk_i,
  input  wire logic                      rstn_i,
  input  wire logic                      ce_i,
  input  wire logic [cpp_pkg::ADDR_W-1:0] addr_i,
  input  wire logic [cpp_pkg::DATA_W-1:0] wdata_i,
  input  wire logic                      wr_i,
  input  wire logic                      rd_i,
  output logic      [cpp_pkg::DATA_W-1:0] rdata_o,
  input  wire logic                      host_mode_i,
  input  wire logic                      vbus_present_i,
  input  wire logic                      input_overvoltage_i,
  input  wire logic                      vbus_load_ok_i,
  input  wire logic                      source_type_i,
  input  wire logic                      boost_usb500_select_i,
  input  wire logic [2:0]                current_limit_pin_i,
  input  wire logic                      charge_en_n_i,
  input  wire logic                      bat_good_i,
  input  wire logic                      bat_above_low_i,
  input  wire logic                      vbus_below_sleep_i,
  input  wire logic                      bat_depleted_i,
  input  wire logic                      bat_below_minsys_i,
  input  wire logic                      sys_above_2v2_i,
  input  wire logic                      sys_below_bat_i,
  input  wire logic                      minsys_regulating_i,
  input  wire logic                      input_current_overload_i,
  input  wire logic                      input_voltage_overload_i,
  input  wire logic                      boost_fault_i,
  input  wire logic                      light_load_i,
  output logic                           power_good_n_o,
  output logic                           int_n_o,
  output logic                           test_load_en_o,
  output logic                           switch_en_o,
  output logic                           battery_switch_on_o,
  output logic                           boost_en_o,
  output logic                           boost_cur_high_o,
  output logic      [2:0]                in_cur_limit_o,
  output logic      [3:0]                vin_limit_o,
  output logic      [2:0]                min_sys_code_o,
  output logic                           charge_cut_o,
  output logic                           pfm_en_o
);
  import cpp_pkg::*;

  // ---------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------
  typedef struct packed {
    cpp_state_t  st;
    logic        high_impedance_state;
    logic [3:0]  vin_lim;
    logic [2:0]  icl;
    logic [1:0]  cfg;
    logic [2:0]  minsys;
    logic        boost_cur;
    logic        force_det;
    logic        batsw_dis;
    logic [1:0]  src;
    logic        input_overload_regulation;
    logic        pg;
    logic        minsys_st;
    logic        boost_flt;
    logic        supplement;
    logic [7:0]  rdata;
    logic        pg_n;
    logic        test_load;
    logic        sw_en;
    logic        batsw_on;
    logic        boost_en;
    logic [2:0]  icl_eff;
    logic        charge_cut;
    logic        pfm;
  } cpp_ctrl_state_t;

  localparam cpp_ctrl_state_t CTRL_RST = '{
    st: ST_NO_INPUT, high_impedance_state: 1'b0, vin_lim: RST_VIN_LIM, icl: RST_ICL,
    cfg: RST_CFG, minsys: RST_MINSYS, boost_cur: RST_BOOST_CUR,
    force_det: 1'b0, batsw_dis: 1'b0, src: SRC_NONE, input_overload_regulation: 1'b0, pg: 1'b0,
    minsys_st: 1'b0, boost_flt: 1'b0, supplement: 1'b0, rdata: 8'h00,
    pg_n: 1'b1, test_load: 1'b0, sw_en: 1'b0, batsw_on: 1'b0,
    boost_en: 1'b0, icl_eff: ICL_100MA, charge_cut: 1'b0, pfm: 1'b0
  };

  cpp_ctrl_state_t r_r;
  cpp_ctrl_state_t r_nxt;

  logic                 tmr_start;
  logic [TMR_W-1:0]     tmr_load;
  logic                 tmr_done;
  logic                 bst_start;
  logic                 bst_done;
  logic                 evt;

  // ---------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------
  function automatic logic [2:0] lower_limit(input logic [2:0] a, input logic [2:0] b);
    lower_limit = (a < b) ? a : b;
  endfunction

  function automatic logic boost_allowed(input logic [1:0] cfg);
    boost_allowed = bat_above_low_i && vbus_below_sleep_i &&
                    boost_usb500_select_i && (cfg == CFG_BOOST);
  endfunction

  // ---------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------
  always_comb begin
    logic host_force;
    logic chg_en;
    r_nxt      = r_r;
    host_force = 1'b0;
    chg_en     = 1'b0;
    tmr_start  = 1'b0;
    tmr_load   = QUAL_CYC_P;
    bst_start  = 1'b0;

    // Host writes, taken before hardware updates so hardware sets win
    if (wr_i) begin
      case (addr_i)
        ADDR_INPUT_SRC: begin
          r_nxt.high_impedance_state     = wdata_i[B_HIZ];
          r_nxt.vin_lim = wdata_i[F_VIN_LSB +: 4];
          r_nxt.icl     = wdata_i[F_ICL_LSB +: 3];
        end
        ADDR_POWER_CFG: begin
          r_nxt.cfg       = wdata_i[F_CFG_LSB +: 2];
          r_nxt.minsys    = wdata_i[F_MINSYS_LSB +: 3];
          r_nxt.boost_cur = wdata_i[B_BOOST_CUR];
        end
        ADDR_MISC_CTRL: begin
          r_nxt.force_det = wdata_i[B_FORCE_DET];
          r_nxt.batsw_dis = wdata_i[B_BATSW_DIS];
          host_force      = wdata_i[B_FORCE_DET];
        end
        default: ;
      endcase
    end

    // Read data stand one cycle, zero otherwise
    r_nxt.rdata = 8'h00;
    if (rd_i) begin
      case (addr_i)
        ADDR_INPUT_SRC: r_nxt.rdata = {r_r.high_impedance_state, r_r.vin_lim, r_r.icl};
        ADDR_POWER_CFG: r_nxt.rdata = {2'h0, r_r.cfg, r_r.minsys, r_r.boost_cur};
        ADDR_MISC_CTRL: r_nxt.rdata = {r_r.force_det, 1'b0, r_r.batsw_dis, 5'h00};
        ADDR_STATUS: begin
          r_nxt.rdata[F_SRC_LSB +: 2] = r_r.src;
          r_nxt.rdata[B_DPM]          = r_r.input_overload_regulation;
          r_nxt.rdata[B_PG]           = r_r.pg;
          r_nxt.rdata[B_MINSYS_ST]    = r_r.minsys_st;
        end
        ADDR_FAULT: begin
          r_nxt.rdata[B_BOOST_FLT] = r_r.boost_flt;
          r_nxt.boost_flt          = 1'b0;
        end
        default: r_nxt.rdata = 8'h00;
      endcase
    end

    unique case (r_r.st)
      ST_NO_INPUT: begin
        r_nxt.pg  = 1'b0;
        r_nxt.src = SRC_NONE;
        if (!vbus_present_i && !host_mode_i) begin
          r_nxt.high_impedance_state = 1'b0;
        end
        if (vbus_present_i && !input_overvoltage_i) begin
          r_nxt.st  = ST_QUALIFY;
          tmr_start = 1'b1;
          tmr_load  = QUAL_CYC_P;
        end else if (boost_allowed(r_r.cfg)) begin
          r_nxt.st  = ST_BOOST_WAIT;
          bst_start = 1'b1;
        end
      end
      ST_QUALIFY: begin
        if (!vbus_present_i) begin
          r_nxt.st = ST_NO_INPUT;
        end else if (tmr_done) begin
          if (!input_overvoltage_i && vbus_load_ok_i) begin
            r_nxt.pg = 1'b1;
            if (r_r.high_impedance_state && host_mode_i && !r_r.force_det) begin
              r_nxt.st = ST_HIGH_Z;
            end else begin
              r_nxt.st = ST_DETECT;
            end
          end else begin
            r_nxt.st  = ST_RETRY;
            tmr_start = 1'b1;
            tmr_load  = RETRY_CYC_P;
          end
        end
      end
      ST_RETRY: begin
        if (!vbus_present_i) begin
          r_nxt.st = ST_NO_INPUT;
        end else if (tmr_done) begin
          r_nxt.st  = ST_QUALIFY;
          tmr_start = 1'b1;
          tmr_load  = QUAL_CYC_P;
        end
      end
      ST_DETECT: begin
        if (source_type_i) begin
          r_nxt.icl = boost_usb500_select_i ? ICL_500MA : ICL_100MA;
          r_nxt.src = SRC_USB;
        end else begin
          r_nxt.icl = ICL_3A;
          r_nxt.src = SRC_ADAPTER;
        end
        r_nxt.force_det = host_force;
        if (source_type_i && !boost_usb500_select_i && bat_good_i) begin
          r_nxt.high_impedance_state = 1'b1;
          r_nxt.st  = ST_HIGH_Z;
        end else begin
          r_nxt.st = ST_RUN;
        end
      end
      ST_HIGH_Z: begin
        if (!vbus_present_i) begin
          r_nxt.st = ST_NO_INPUT;
        end else if (r_r.force_det) begin
          r_nxt.st = ST_DETECT;
        end else if (!r_nxt.high_impedance_state) begin
          r_nxt.st = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!vbus_present_i) begin
          r_nxt.st = ST_NO_INPUT;
        end else if (r_r.force_det) begin
          r_nxt.st = ST_DETECT;
        end else if (r_nxt.high_impedance_state) begin
          r_nxt.st = ST_HIGH_Z;
        end
      end
      ST_BOOST_WAIT: begin
        if (!boost_allowed(r_r.cfg) || vbus_present_i && !vbus_below_sleep_i) begin
          r_nxt.st = ST_NO_INPUT;
        end else if (bst_done) begin
          r_nxt.st = ST_BOOST;
        end
      end
      ST_BOOST: begin
        r_nxt.src = SRC_BOOST;
        if (boost_fault_i) begin
          r_nxt.boost_flt = 1'b1;
          r_nxt.st        = ST_NO_INPUT;
        end else if (!boost_allowed(r_r.cfg)) begin
          r_nxt.st = ST_NO_INPUT;
        end
      end
    endcase

    // Supplement tracking while the converter runs
    if (r_nxt.st == ST_RUN) begin
      if (sys_below_bat_i) begin
        r_nxt.supplement = 1'b1;
      end else if (bat_depleted_i) begin
        r_nxt.supplement = 1'b0;
      end
    end else begin
      r_nxt.supplement = 1'b0;
    end

    // Registered outputs and sampled status
    chg_en = (r_nxt.cfg == CFG_CHARGE) && !charge_en_n_i && !r_nxt.batsw_dis;
    r_nxt.pg_n      = !r_nxt.pg;
    r_nxt.test_load = (r_nxt.st == ST_QUALIFY);
    r_nxt.sw_en     = (r_nxt.st == ST_RUN);
    r_nxt.boost_en  = (r_nxt.st == ST_BOOST);
    if (r_nxt.batsw_dis) begin
      r_nxt.batsw_on = 1'b0;
    end else if (r_nxt.st == ST_RUN) begin
      r_nxt.batsw_on = chg_en || r_nxt.supplement;
    end else if (r_nxt.st == ST_BOOST_WAIT || r_nxt.st == ST_BOOST) begin
      r_nxt.batsw_on = 1'b1;
    end else begin
      r_nxt.batsw_on = !bat_depleted_i;
    end
    r_nxt.icl_eff = sys_above_2v2_i ? lower_limit(r_nxt.icl, current_limit_pin_i)
                                    : ICL_100MA;
    r_nxt.charge_cut = (r_nxt.st == ST_RUN) &&
                       (input_current_overload_i || input_voltage_overload_i);
    r_nxt.input_overload_regulation        = r_nxt.charge_cut;
    r_nxt.minsys_st  = minsys_regulating_i;
    r_nxt.pfm = light_load_i && (bat_below_minsys_i || !chg_en) &&
                (r_nxt.st == ST_RUN || r_nxt.st == ST_BOOST);

    // Any status change, or a new fault, raises an interrupt pulse
    evt = (r_nxt.src != r_r.src) || (r_nxt.input_overload_regulation != r_r.input_overload_regulation) ||
          (r_nxt.pg != r_r.pg) || (r_nxt.minsys_st != r_r.minsys_st) ||
          (r_nxt.boost_flt && !r_r.boost_flt);
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      r_r <= CTRL_RST;
    end else if (ce_i) begin
      r_r <= r_nxt;
    end
  end

  // ---------------------------------------------------------------------
  // Timers and interrupt
  // ---------------------------------------------------------------------
  cpp_timer u_qual_tmr (
    .clk_i   (clk_i),
    .rstn_i  (rstn_i),
    .ce_i    (ce_i),
    .start_i (tmr_start),
    .load_i  (tmr_load),
    .done_o  (tmr_done)
  );

  cpp_timer u_boost_tmr (
    .clk_i   (clk_i),
    .rstn_i  (rstn_i),
    .ce_i    (ce_i),
    .start_i (bst_start),
    .load_i  (BOOST_CYC_P),
    .done_o  (bst_done)
  );

  cpp_int_pulse u_int (
    .clk_i   (clk_i),
    .rstn_i  (rstn_i),
    .ce_i    (ce_i),
    .event_i (evt),
    .int_n_o (int_n_o)
  );

  assign rdata_o             = r_r.rdata;
  assign power_good_n_o      = r_r.pg_n;
  assign test_load_en_o      = r_r.test_load;
  assign switch_en_o         = r_r.sw_en;
  assign battery_switch_on_o = r_r.batsw_on;
  assign boost_en_o          = r_r.boost_en;
  assign boost_cur_high_o    = r_r.boost_cur;
  assign in_cur_limit_o      = r_r.icl_eff;
  assign vin_limit_o         = r_r.vin_lim;
  assign min_sys_code_o      = r_r.minsys;
  assign charge_cut_o        = r_r.charge_cut;
  assign pfm_en_o            = r_r.pfm;

endmodule

`default_nettype wire

// *** src/cpp_int_pulse.sv ***
// Purpose : Stretches a status event into an active-low interrupt pulse.
// Assumes : event_i is a one-cycle pulse from the control logic.
// Notes   : An event during a pulse restarts the pulse.
`default_nettype none

module cpp_int_pulse (
  input  wire logic clk_i,
  input  wire logic rstn_i,
  input  wire logic ce_i,
  input  wire logic event_i,
  output logic      int_n_o
);
  import cpp_pkg::*;

  typedef struct packed {
    logic [INT_W-1:0] cnt;
    logic             int_n;
  } cpp_int_state_t;

  localparam cpp_int_state_t INT_RST = '{cnt: '0, int_n: 1'b1};
  localparam logic [INT_W-1:0] ONE   = INT_W'(1);

  cpp_int_state_t r_r;
  cpp_int_state_t r_nxt;

  always_comb begin
    r_nxt = r_r;
    if (event_i) begin
      r_nxt.cnt   = INT_PULSE_CYC;
      r_nxt.int_n = 1'b0;
    end else if (r_r.cnt != '0) begin
      r_nxt.cnt = r_r.cnt - ONE;
      if (r_r.cnt == ONE) begin
        r_nxt.int_n = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      r_r <= INT_RST;
    end else if (ce_i) begin
      r_r <= r_nxt;
    end
  end

  assign int_n_o = r_r.int_n;

endmodule

`default_nettype wire

// *** src/cpp_pkg.sv ***
// Purpose : Shared constants and types of the charger input power path control.
// Assumes : 20 MHz internal clock, 8-bit register port with 4-bit address.
// Notes   : Limit and voltage fields are codes; the analog side interprets them.
`default_nettype none

package cpp_pkg;

  // ---------------------------------------------------------------------
  // Clock and times
  // ---------------------------------------------------------------------
  localparam longint unsigned CLK_HZ        = 64'd20_000_000;
  localparam longint unsigned QUAL_TIME_MS  = 64'd10;
  localparam longint unsigned RETRY_TIME_MS = 64'd2000;
  localparam longint unsigned BOOST_DLY_MS  = 64'd220;
  localparam longint unsigned INT_PULSE_US  = 64'd100;

  localparam int TMR_W = 26;
  localparam int INT_W = 12;

  localparam logic [TMR_W-1:0] QUAL_CYC      = TMR_W'((QUAL_TIME_MS * CLK_HZ) / 64'd1000);
  localparam logic [TMR_W-1:0] RETRY_CYC     = TMR_W'((RETRY_TIME_MS * CLK_HZ) / 64'd1000);
  localparam logic [TMR_W-1:0] BOOST_DLY_CYC = TMR_W'((BOOST_DLY_MS * CLK_HZ) / 64'd1000);
  localparam logic [INT_W-1:0] INT_PULSE_CYC = INT_W'((INT_PULSE_US * CLK_HZ) / 64'd1_000_000);

  // ---------------------------------------------------------------------
  // Register port and map
  // ---------------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;

  localparam logic [ADDR_W-1:0] ADDR_INPUT_SRC = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_POWER_CFG = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_MISC_CTRL = 4'h7;
  localparam logic [ADDR_W-1:0] ADDR_STATUS    = 4'h8;
  localparam logic [ADDR_W-1:0] ADDR_FAULT     = 4'h9;

  localparam int B_HIZ        = 7;
  localparam int F_VIN_LSB    = 3;
  localparam int F_ICL_LSB    = 0;
  localparam int F_CFG_LSB    = 4;
  localparam int F_MINSYS_LSB = 1;
  localparam int B_BOOST_CUR  = 0;
  localparam int B_FORCE_DET  = 7;
  localparam int B_BATSW_DIS  = 5;
  localparam int F_SRC_LSB    = 6;
  localparam int B_DPM        = 3;
  localparam int B_PG         = 2;
  localparam int B_MINSYS_ST  = 0;
  localparam int B_BOOST_FLT  = 6;

  // Reset values
  localparam logic [3:0] RST_VIN_LIM   = 4'h6;
  localparam logic [2:0] RST_ICL       = 3'h2;
  localparam logic [1:0] RST_CFG       = 2'h1;
  localparam logic [2:0] RST_MINSYS    = 3'h5;
  localparam logic       RST_BOOST_CUR = 1'b1;

  // Input current limit codes
  localparam logic [2:0] ICL_100MA = 3'h0;
  localparam logic [2:0] ICL_500MA = 3'h2;
  localparam logic [2:0] ICL_3A    = 3'h7;

  // Charge-config and source-status codes
  localparam logic [1:0] CFG_CHARGE  = 2'h1;
  localparam logic [1:0] CFG_BOOST   = 2'h2;
  localparam logic [1:0] SRC_NONE    = 2'h0;
  localparam logic [1:0] SRC_USB     = 2'h1;
  localparam logic [1:0] SRC_ADAPTER = 2'h2;
  localparam logic [1:0] SRC_BOOST   = 2'h3;

  typedef enum logic [2:0] {
    ST_NO_INPUT,
    ST_QUALIFY,
    ST_RETRY,
    ST_DETECT,
    ST_HIGH_Z,
    ST_RUN,
    ST_BOOST_WAIT,
    ST_BOOST
  } cpp_state_t;

endpackage

`default_nettype wire

// *** src/cpp_timer.sv ***
// Purpose : One-shot down counter that pulses done after a loaded count.
// Assumes : load_i is at least one.
// Notes   : A new start reloads the count even while busy.
`default_nettype none

module cpp_timer (
  input  wire logic                     clk_i,
  input  wire logic                     rstn_i,
  input  wire logic                     ce_i,
  input  wire logic                     start_i,
  input  wire logic [cpp_pkg::TMR_W-1:0] load_i,
  output logic                          done_o
);
  import cpp_pkg::*;

  typedef struct packed {
    logic [TMR_W-1:0] cnt;
    logic             busy;
    logic             done;
  } cpp_tmr_state_t;

  localparam cpp_tmr_state_t TMR_RST = '{cnt: '0, busy: 1'b0, done: 1'b0};
  localparam logic [TMR_W-1:0] ONE   = TMR_W'(1);

  cpp_tmr_state_t r_r;
  cpp_tmr_state_t r_nxt;

  always_comb begin
    r_nxt      = r_r;
    r_nxt.done = 1'b0;
    if (start_i) begin
      r_nxt.cnt  = load_i;
      r_nxt.busy = 1'b1;
    end else if (r_r.busy) begin
      r_nxt.cnt = r_r.cnt - ONE;
      if (r_r.cnt == ONE) begin
        r_nxt.busy = 1'b0;
        r_nxt.done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      r_r <= TMR_RST;
    end else if (ce_i) begin
      r_r <= r_nxt;
    end
  end

  assign done_o = r_r.done;

endmodule

`default_nettype wire
